/* src/lhp_pkg.sv */
// Shared types and constants for the LCD host nibble port
package lhp_pkg;
    // System clock and the internal oscillator it stands in for
    localparam int unsigned SysClkHz = 100_000_000;
    localparam int unsigned OscHz = 80_000;
    localparam int unsigned OscDiv = SysClkHz / OscHz;
    localparam logic [10:0] OscDivLast = 11'(OscDiv - 1);
    // Frame geometry in oscillator periods
    localparam logic [5:0] ClksPerSlot = 6'h3c;
    localparam logic [4:0] SlotsPerFrame = 5'h12;
    // Least reset-low width, in microseconds, for the far side
    localparam int unsigned ResetLowWidthUs = 1200;
    localparam int unsigned ResetLowWidthCyc =
        ResetLowWidthUs * (SysClkHz / 1_000_000);
    // Interface-width command: upper nibble 001x selects width by bit 4
    localparam logic [2:0] WidthCmdTop = 3'h1;
    localparam int unsigned WidthBit = 4;

    // Bus-side signals of one strobe
    typedef struct packed {
        logic strobe;
        logic registerSelectLine;
        logic readNotWrite;
        logic [7:0] hostDataLine;
    } lhp_bus_t;

    // One assembled transfer handed inward
    typedef struct packed {
        logic registerSelectLine;
        logic [7:0] data;
    } lhp_word_t;

    typedef enum logic [1:0] {
        PH_UPPER = 2'b01,
        PH_LOWER = 2'b10
    } lhp_phase_t;

    // Complete state of the port
    typedef struct packed {
        logic strobePrev;
        logic halfByte;
        lhp_phase_t phase;
        logic [3:0] upperHeld;
        logic [7:0] readData;
        logic [10:0] oscCnt;
        logic oscTick;
        logic [5:0] slotClk;
        logic [4:0] slot;
        logic frameTick;
        logic [1:0] bufCnt;
        lhp_word_t buf0;
        lhp_word_t buf1;
        logic outValid;
        logic inReady;
        logic dataOe;
    } lhp_state_t;
endpackage : lhp_pkg

/* src/lhp_port.sv */
// Host-side parallel port with nibble sequencing and frame timing
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1: Internal 80 kHz tick, 12.5 us period
// R2: Frame is 60 clocks times 18 slots
// R3: Byte moves in one or two strobes
// R4: Half-byte mode ignores lower four lines
// R5: Upper nibble first, lower nibble second
// R6: Host polls busy only after both halves
// R7: Status read returned as two nibbles
// R8: Reset held low at least 1.2 ms; the port never times it and the testbench releases it after two clocks
// R9: Bad supply ramp needs instruction initialisation
// R10: No busy poll before last width command
// R11: Width command 0010 sent as one byte
// R12: Nibble phase toggles, resets on width change
module lhp_port
    import lhp_pkg::*;
(
    input wire logic clk, // 100 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire lhp_bus_t bus, // Host strobe, select, direction, data
    input wire logic busyIndication, // Core busy state
    input wire logic [6:0] addressCounter, // Core address counter
    input wire logic [7:0] dataIn, // Core read data for data reads
    input wire logic outReady, // Core accepts a word
    output logic outValid, // Word waiting for core
    output lhp_word_t outWord, // Assembled word
    output logic inReady, // Buffer has room
    output logic [7:0] hostDataOut, // Read data to host lines
    output logic hostDataOe, // High while driving host lines
    output logic halfByteMode, // Current transfer width
    output logic oscTick, // One pulse per oscillator period
    output logic frameTick // One pulse per frame
);
    lhp_state_t s_q, s_d;
    logic fall, writeDone, pop;
    lhp_word_t inWord;
    logic [7:0] readByte;

    // Assemble nibbles into a byte, upper half first
    function automatic logic [7:0] joinNib(input logic [3:0] hi,
                                           input logic [3:0] lo);
        joinNib = {hi, lo};
    endfunction : joinNib

    always_comb
    begin
        s_d = s_q;
        fall = s_q.strobePrev & ~bus.strobe;
        writeDone = 1'b0;
        inWord = '0;
        inWord.registerSelectLine = bus.registerSelectLine;
        s_d.strobePrev = bus.strobe;
        // Drive enable registered so the pin never follows a raw input
        s_d.dataOe = bus.strobe & bus.readNotWrite; // [R3]
        // Status byte or core data, latched per read
        readByte = bus.registerSelectLine ? dataIn
            : {busyIndication, addressCounter};
        // Oscillator stand-in: divider tick
        s_d.oscTick = 1'b0; // [R1]
        if (s_q.oscCnt == OscDivLast)
        begin
            s_d.oscCnt = '0;
            s_d.oscTick = 1'b1; // [R1]
        end
        else
            s_d.oscCnt = s_q.oscCnt + 11'h1;
        // Frame: 60 ticks per slot, 18 slots
        s_d.frameTick = 1'b0;
        if (s_q.oscTick)
        begin
            if (s_q.slotClk == ClksPerSlot - 6'h1)
            begin
                s_d.slotClk = '0; // [R2]
                if (s_q.slot == SlotsPerFrame - 5'h1)
                begin
                    s_d.slot = '0;
                    s_d.frameTick = 1'b1; // [R2]
                end
                else
                    s_d.slot = s_q.slot + 5'h1;
            end
            else
                s_d.slotClk = s_q.slotClk + 6'h1;
        end
        // Present read data every cycle the read strobe stands high; nibble picked by phase
        if (bus.strobe && bus.readNotWrite)
        begin
            if (!s_q.halfByte)
                s_d.readData = readByte; // [R3]
            else if (s_q.phase == PH_UPPER)
                s_d.readData = {readByte[7:4], 4'h0}; // [R7]
            else
                s_d.readData = {s_q.upperHeld, 4'h0}; // [R7]
        end
        // Strobe falling edge completes a bus cycle
        if (fall)
        begin
            if (!s_q.halfByte)
            begin
                inWord.data = bus.hostDataLine; // [R3]
                writeDone = ~bus.readNotWrite;
            end
            else if (s_q.phase == PH_UPPER)
            begin
                // Only upper lines matter; keep half for second cycle
                s_d.upperHeld = bus.readNotWrite ? readByte[3:0]
                    : bus.hostDataLine[7:4]; // [R4] [R5]
                s_d.phase = PH_LOWER; // [R12]
            end
            else
            begin
                inWord.data = joinNib(s_q.upperHeld,
                    bus.hostDataLine[7:4]); // [R5]
                writeDone = ~bus.readNotWrite;
                s_d.phase = PH_UPPER; // [R12]
            end
            // Width command switches mode and realigns the phase
            if (writeDone && !bus.registerSelectLine
                && inWord.data[7:5] == WidthCmdTop)
            begin
                s_d.halfByte = ~inWord.data[WidthBit]; // [R11]
                s_d.phase = PH_UPPER; // [R12]
            end
        end
        // Two-entry buffer; a write arriving while full is dropped, as inReady warns
        pop = outReady && (s_q.bufCnt != 2'h0);
        if (pop)
        begin
            s_d.buf0 = s_q.buf1;
            s_d.bufCnt = s_q.bufCnt - 2'h1;
        end
        if (writeDone && s_q.bufCnt != 2'h2)
        begin
            if (s_d.bufCnt == 2'h0)
                s_d.buf0 = inWord;
            else
                s_d.buf1 = inWord;
            s_d.bufCnt = s_d.bufCnt + 2'h1;
        end
        // Flags registered alongside the count they describe
        s_d.outValid = s_d.bufCnt != 2'h0;
        s_d.inReady = s_d.bufCnt != 2'h2;
    end

    // Single register for all port state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.phase <= PH_UPPER; // [R12]
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from state
    assign outValid = s_q.outValid;
    assign outWord = s_q.buf0;
    assign inReady = s_q.inReady;
    assign hostDataOut = s_q.readData;
    assign hostDataOe = s_q.dataOe;
    assign halfByteMode = s_q.halfByte;
    assign oscTick = s_q.oscTick;
    assign frameTick = s_q.frameTick;

    // Checks
    sequence s_upperWrite;
        s_q.halfByte && s_q.phase == PH_UPPER && fall && !bus.readNotWrite;
    endsequence

    property p_phaseToggle;
        @(posedge clk) disable iff (!resetn)
        s_upperWrite |=> s_q.phase == PH_LOWER;
    endproperty
    a_phaseToggle: assert property (p_phaseToggle) // [R12]
        else $error("phase did not advance");

    property p_upperKept;
        @(posedge clk) disable iff (!resetn)
        s_upperWrite |=> s_q.upperHeld == $past(bus.hostDataLine[7:4]);
    endproperty
    a_upperKept: assert property (p_upperKept) // [R5]
        else $error("upper nibble not held");

    property p_osc;
        @(posedge clk) disable iff (!resetn)
        oscTick |=> !oscTick [*8];
    endproperty
    a_osc: assert property (p_osc) // [R1]
        else $error("oscillator tick too close");

    property p_frame;
        @(posedge clk) disable iff (!resetn)
        frameTick |-> s_q.slot == 5'h0 && s_q.slotClk == 6'h0;
    endproperty
    a_frame: assert property (p_frame) // [R2]
        else $error("frame tick off slot zero");

    property p_fullWrite;
        @(posedge clk) disable iff (!resetn)
        !s_q.halfByte && fall && !bus.readNotWrite && s_q.bufCnt == 2'h0
        |=> outValid && outWord.data == $past(bus.hostDataLine);
    endproperty
    a_fullWrite: assert property (p_fullWrite) // [R3]
        else $error("byte write lost");

    property p_statusRead;
        @(posedge clk) disable iff (!resetn)
        s_q.halfByte && s_q.phase == PH_UPPER && bus.strobe
        && bus.readNotWrite && !bus.registerSelectLine
        |=> hostDataOut[7] == $past(busyIndication);
    endproperty
    a_statusRead: assert property (p_statusRead) // [R7]
        else $error("busy not first nibble");

    property p_lowIgnored;
        @(posedge clk) disable iff (!resetn)
        s_q.halfByte && s_q.phase == PH_LOWER && fall
        && !bus.readNotWrite && s_q.bufCnt == 2'h0
        |=> outWord.data[3:0] == $past(bus.hostDataLine[7:4]);
    endproperty
    a_lowIgnored: assert property (p_lowIgnored) // [R4]
        else $error("lower lines used");

    property p_widthCmd;
        @(posedge clk) disable iff (!resetn)
        !s_q.halfByte && fall && !bus.readNotWrite
        && !bus.registerSelectLine && bus.hostDataLine[7:4] == 4'h2
        |=> s_q.halfByte && s_q.phase == PH_UPPER;
    endproperty
    a_widthCmd: assert property (p_widthCmd) // [R11]
        else $error("width command missed");
endmodule : lhp_port
`default_nettype wire

/* test/lhp_host_model.sv */
// Host bus master model for the port's strobe interface
`timescale 1ns/1ns
`default_nettype none
module lhp_host_model
    import lhp_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic [7:0] hostDataOut, // Device read data
    input wire logic hostDataOe, // Device drives data lines
    output var lhp_bus_t bus // Strobe, select, direction, data
);
    // Drive enable seen while the last strobe stood high
    logic oeSeen = 1'b0;

    // Idle bus: strobe low, released lines sit at the pull-up level
    initial bus = '{1'b0, 1'b1, 1'b1, 8'hff};

    // One strobe held two cycles; lines kept until the fall is seen
    task automatic cycle(input logic rs, input logic rnw,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk) bus <= '{1'b1, rs, rnw, rnw ? 8'hff : d};
        @(posedge clk);
        @(posedge clk) q = hostDataOut;
        oeSeen = hostDataOe;
        bus.strobe <= 1'b0;
        // Write data is taken at the fall, so release only after it
        @(posedge clk) bus <= '{1'b0, 1'b1, 1'b1, 8'hff};
        @(posedge clk);
    endtask : cycle

    // Byte as two halves; junk on the low lines must be ignored
    task automatic nib(input logic rs, input logic [7:0] b);
        logic [7:0] q;
        cycle(rs, 1'b0, {b[7:4], ~b[3:0]}, q);
        cycle(rs, 1'b0, {b[3:0], b[7:4]}, q);
    endtask : nib
endmodule : lhp_host_model
`default_nettype wire

/* test/tb_lhp_port.sv */
// Self-checking testbench for the host nibble port
`timescale 1ns/1ns
`default_nettype none
module tb_lhp_port
    import lhp_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic busyIndication = 1'b0;
    logic [6:0] addressCounter = 7'h00;
    logic [7:0] dataIn = 8'h00;
    logic outReady = 1'b0;
    lhp_bus_t bus;
    lhp_word_t outWord;
    logic outValid, inReady, hostDataOe, halfByteMode, oscTick, frameTick;
    logic [7:0] hostDataOut, q;
    int mismatches = 0;
    int checkCount = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    lhp_port dut_u (.clk(clk), .resetn(resetn), .bus(bus),
        .busyIndication(busyIndication), .addressCounter(addressCounter),
        .dataIn(dataIn), .outReady(outReady), .outValid(outValid),
        .outWord(outWord), .inReady(inReady), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .halfByteMode(halfByteMode),
        .oscTick(oscTick), .frameTick(frameTick));
    lhp_host_model host_u (.clk(clk), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .bus(bus));

    task automatic conclude();
        $display("mismatches %0d checks %0d", mismatches, checkCount);
        if (mismatches == 0 && checkCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // A wait that used up its bound ends the run
    task automatic bound(input int n);
        if (n >= 2000)
        begin
            mismatches++;
            conclude();
        end
    endtask : bound

    // Pop one word; starts a cycle late so the last pop has landed
    task automatic pop(input logic [8:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        while (outValid !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        bound(n);
        chk({7'h0, outWord}, {7'h0, exp});
        outReady <= 1'b1;
        @(posedge clk) outReady <= 1'b0;
    endtask : pop

    // Full-byte write and data read
    task automatic t_byte8();
        host_u.cycle(1'b1, 1'b0, 8'ha5, q);
        pop({1'b1, 8'ha5});
        dataIn <= 8'h3c;
        host_u.cycle(1'b1, 1'b1, 8'h00, q);
        chk({8'h0, q}, 16'h003c);
        chk({15'h0, host_u.oeSeen}, 16'h0001);
        chk({15'h0, hostDataOe}, 16'h0000);
    endtask : t_byte8

    // Fill the buffer while the core stalls, then drain it
    task automatic t_buffer();
        host_u.cycle(1'b1, 1'b0, 8'h11, q);
        host_u.cycle(1'b1, 1'b0, 8'h22, q);
        chk({15'h0, inReady}, 16'h0000);
        host_u.cycle(1'b1, 1'b0, 8'h33, q);
        pop({1'b1, 8'h11});
        pop({1'b1, 8'h22});
        @(posedge clk);
        chk({15'h0, outValid}, 16'h0000);
    endtask : t_buffer

    // Enter half mode, write halves, status read, leave half mode
    task automatic t_half();
        // Width set by instruction rather than by power-on defaults
        host_u.cycle(1'b0, 1'b0, 8'h20, q);
        chk({15'h0, halfByteMode}, 16'h0001);
        pop({1'b0, 8'h20});
        host_u.nib(1'b1, 8'hc3);
        pop({1'b1, 8'hc3});
        busyIndication <= 1'b1;
        addressCounter <= 7'h5a;
        host_u.cycle(1'b0, 1'b1, 8'h00, q);
        chk({8'h0, q}, 16'h00d0);
        host_u.cycle(1'b0, 1'b1, 8'h00, q);
        chk({8'h0, q}, 16'h00a0);
        host_u.nib(1'b0, 8'h30);
        chk({15'h0, halfByteMode}, 16'h0000);
        pop({1'b0, 8'h30});
        host_u.cycle(1'b1, 1'b0, 8'h5e, q);
        pop({1'b1, 8'h5e});
    endtask : t_half

    // Oscillator tick spacing in system clocks
    task automatic t_osc();
        int n;
        n = 0;
        while (oscTick !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        bound(n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (oscTick !== 1'b1 && n < 2000);
        bound(n);
        chk(16'(n), 16'(OscDiv));
        // Whole run is far shorter than one frame of ticks
        chk({15'h0, frameTick}, 16'h0000);
    endtask : t_osc

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        // Short pulse: the port never times the reset width
        resetn <= 1'b1;
        @(posedge clk);
        chk({14'h0, outValid, halfByteMode}, 16'h0000);
        t_byte8();
        t_buffer();
        t_half();
        t_osc();
        conclude();
    end
endmodule : tb_lhp_port
`default_nettype wire
